/* ohb_device_end.sv */
// display side of the host bus port: strobe decode, serial shift, readback
`timescale 1ns/1ps
// Overview of operation
// [RULE1] enable style: high enable, low select starts cycle
// [RULE2] strobe style: low read and select start read
// [RULE3] enable style: host sets direction high read, low write
// [RULE4] strobe style: low write and select start write
// [RULE5] serial: host grounds both strobe pins
// [RULE6] parallel: eight-bit two-way data bus
// [RULE7] serial: data on line one, clock on zero
// [RULE8] host grounds unused data lines, line two excepted; host end drives line two low as well
// [RULE9] data/command high: display data; low: command
// [RULE10] respond only while chip select is low
// [RULE11] low reset input initialises the whole port
// [RULE12] three-wire serial: host grounds data/command pin
// [RULE13] enable style: capture write at enable fall
// [RULE14] release bus unless selected read cycle active
module ohb_device_end
#(
	parameter int DEPTH = 2
)
(
	input  wire logic              clk,         // system clock
	input  wire logic              sys_rst,     // async reset
	ohb_link_if.device             lk,          // pins toward host
	input  wire ohb_pkg::ohb_byte_t read_byte,  // byte returned on reads
	output logic                   read_strobe, // read cycle began
	output logic                   out_valid,   // received word waiting
	input  wire logic              out_ready,   // consumer takes word
	output ohb_pkg::ohb_byte_t     out_byte,    // received byte
	output logic                   out_is_data, // 1 display data, 0 command
	output logic                   init_active, // reset pin held low
	output logic                   lost_word    // word dropped, buffer full
);
	import ohb_pkg::*;

	generate
		if (DEPTH < 2)
		begin : g_bad_depth
			$error("device buffer needs at least two entries");
		end
	endgenerate

	ohb_mode_t              mode;
	logic                   sel, sclk, serial_data_in;
	logic                   en_q, en_d;
	logic                   wr_q, wr_d;
	logic                   sel_q, sel_d;
	logic                   sclk_q, sclk_d;
	logic                   rd_act, rd_act_q, rd_act_d;
	logic [WORD_W-1:0]      sh_q, sh_d, sh_next;
	logic [SER_CNT_W-1:0]   cnt_q, cnt_d;
	logic                   cap_v;
	ohb_byte_t              cap_byte;
	logic                   cap_dc;
	logic                   pend_q, pend_d;
	ohb_byte_t              pend_byte_q, pend_byte_d;
	logic                   pend_dc_q, pend_dc_d;
	logic                   lost_q, lost_d;
	logic                   init_q, init_d;
	logic                   rs_q, rs_d;
	ohb_byte_t              do_q, do_d;
	logic                   oe_q, oe_d;
	logic                   fifo_in_ready;
	logic                   fifo_out_valid;
	logic [WORD_W-1:0]      fifo_out_data;
	logic                   in_reset;

	assign mode     = ohb_mode_t'({lk.bus_select_bit1, lk.bus_select_bit0});
	assign sel      = !lk.cs_n;                                 // [RULE10]
	assign in_reset = !lk.reset_n;                              // [RULE11]
	assign sclk     = lk.host_data_bus[SCLK_BIT];               // [RULE7]
	assign serial_data_in     = lk.host_data_bus[SERIAL_DATA_IN_BIT];               // [RULE7]
	assign sh_next  = {sh_q[WORD_W-2:0], serial_data_in};

	// read cycle detection per parallel scheme
	always_comb
	begin
		case (mode)
			OHB_PAR68:
				rd_act = sel && lk.en_rd && lk.rw_wr;               // [RULE1]
			OHB_PAR80:
				rd_act = sel && !lk.en_rd;                          // [RULE2]
			default:
				rd_act = 1'b0;
		endcase
	end

	// byte capture: parallel strobes and serial shifter
	always_comb
	begin
		en_d     = lk.en_rd;
		wr_d     = lk.rw_wr;
		sel_d    = sel;
		sclk_d   = sclk;
		sh_d     = sh_q;
		cnt_d    = cnt_q;
		cap_v    = 1'b0;
		cap_byte = lk.host_data_bus;
		cap_dc   = lk.dc;
		case (mode)
			OHB_PAR68:
			begin
				// write ends as enable falls, data still held
				cap_v = sel_q && en_q && !lk.en_rd && !lk.rw_wr;  // [RULE13]
			end
			OHB_PAR80:
			begin
				// write strobe low then released ends the write
				cap_v = sel_q && !wr_q && lk.rw_wr;                // [RULE4]
			end
			default:
			begin
				if (!sel)
					cnt_d = '0;                                    // [RULE10]
				else if (!sclk_q && sclk)
				begin
					sh_d = sh_next;                                // [RULE7]
					if (cnt_q == ohb_ser_bits(mode) - SER_CNT_W'(1))
					begin
						cnt_d    = '0;
						cap_v    = 1'b1;
						cap_byte = sh_next[BYTE_W-1:0];
						// three-wire carries the select as first bit
						if (mode == OHB_SER3)
							cap_dc = sh_next[WORD_W-1];
					end
					else
						cnt_d = cnt_q + SER_CNT_W'(1);
				end
			end
		endcase
		if (in_reset)
		begin
			sh_d  = '0;                                            // [RULE11]
			cnt_d = '0;
			cap_v = 1'b0;
		end
	end

	// holding slot ahead of the buffer, readback drive
	always_comb
	begin
		pend_d      = pend_q;
		pend_byte_d = pend_byte_q;
		pend_dc_d   = pend_dc_q;
		lost_d      = lost_q;
		if (pend_q && fifo_in_ready)
			pend_d = 1'b0;
		if (cap_v)
		begin
			if (pend_d)
				lost_d = 1'b1;
			pend_d      = 1'b1;
			pend_byte_d = cap_byte;
			pend_dc_d   = cap_dc;                                  // [RULE9]
		end
		rd_act_d = rd_act;
		rs_d     = rd_act && !rd_act_q;
		do_d     = rs_d ? read_byte : do_q;
		oe_d     = rd_act;                                         // [RULE6] [RULE14]
		init_d   = in_reset;
		if (in_reset)
		begin
			pend_d   = 1'b0;                                       // [RULE11]
			lost_d   = 1'b0;
			rd_act_d = 1'b0;
			rs_d     = 1'b0;
			oe_d     = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			en_q        <= 1'b0;
			wr_q        <= 1'b1;
			sel_q       <= 1'b0;
			sclk_q      <= 1'b0;
			sh_q        <= '0;
			cnt_q       <= '0;
			pend_q      <= 1'b0;
			pend_byte_q <= BYTE_ZERO;
			pend_dc_q   <= 1'b0;
			lost_q      <= 1'b0;
			init_q      <= 1'b1;
			rd_act_q    <= 1'b0;
			rs_q        <= 1'b0;
			do_q        <= BYTE_ZERO;
			oe_q        <= 1'b0;
		end
		else
		begin
			en_q        <= en_d;
			wr_q        <= wr_d;
			sel_q       <= sel_d;
			sclk_q      <= sclk_d;
			sh_q        <= sh_d;
			cnt_q       <= cnt_d;
			pend_q      <= pend_d;
			pend_byte_q <= pend_byte_d;
			pend_dc_q   <= pend_dc_d;
			lost_q      <= lost_d;
			init_q      <= init_d;
			rd_act_q    <= rd_act_d;
			rs_q        <= rs_d;
			do_q        <= do_d;
			oe_q        <= oe_d;
		end
	end

	ohb_fifo
	#(
		.WIDTH (WORD_W),
		.DEPTH (DEPTH)
	)
	u_buf
	(
		.clk       (clk),
		.sys_rst   (sys_rst),
		.flush     (in_reset),
		.in_valid  (pend_q),
		.in_ready  (fifo_in_ready),
		.in_data   ({pend_dc_q, pend_byte_q}),
		.out_valid (fifo_out_valid),
		.out_ready (out_ready),
		.out_data  (fifo_out_data)
	);

	assign out_valid   = fifo_out_valid;
	assign out_byte    = fifo_out_data[BYTE_W-1:0];
	assign out_is_data = fifo_out_data[WORD_W-1];
	assign lk.dev_do   = do_q;
	assign lk.dev_oe   = oe_q;
	assign read_strobe = rs_q;
	assign init_active = init_q;
	assign lost_word   = lost_q;
endmodule

/* ohb_pkg.sv */
// shared constants, modes and types for the oled host bus port
package ohb_pkg;
	localparam int BYTE_W        = 8;
	localparam int WORD_W        = BYTE_W + 1;
	localparam int SCLK_BIT      = 0;
	localparam int SERIAL_DATA_IN_BIT      = 1;
	localparam int SER_BITS_4W   = 8;
	localparam int SER_BITS_3W   = 9;
	localparam int SER_CNT_W     = 4;
	localparam int TMR_W         = 4;
	localparam int CLK_PERIOD_NS = 25;
	localparam int PAR_PHASE_NS  = 150;
	localparam int SER_HALF_NS   = 50;
	// least times, rounded up to whole cycles
	localparam int PAR_PHASE_CYC = (PAR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SER_HALF_CYC  = (SER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef logic [BYTE_W-1:0] ohb_byte_t;

	// {bus_select_bit1, bus_select_bit0}
	typedef enum logic [1:0]
	{
		OHB_SER4  = 2'h0,
		OHB_SER3  = 2'h1,
		OHB_PAR80 = 2'h2,
		OHB_PAR68 = 2'h3
	} ohb_mode_t;

	localparam ohb_byte_t BYTE_ZERO = 8'h00;

	function automatic logic ohb_is_serial(input ohb_mode_t m);
		ohb_is_serial = (m == OHB_SER4) || (m == OHB_SER3);
	endfunction

	function automatic logic [SER_CNT_W-1:0] ohb_ser_bits(input ohb_mode_t m);
		ohb_ser_bits = (m == OHB_SER3) ? SER_CNT_W'(SER_BITS_3W) : SER_CNT_W'(SER_BITS_4W);
	endfunction
endpackage

/* ohb_link_if.sv */
// pin bundle between host end and device end
`timescale 1ns/1ps
interface ohb_link_if;
	import ohb_pkg::*;
	logic      cs_n;
	logic      dc;
	logic      en_rd;
	logic      rw_wr;
	logic      reset_n;
	logic      bus_select_bit0;
	logic      bus_select_bit1;
	ohb_byte_t host_do;
	logic      host_oe;
	ohb_byte_t dev_do;
	logic      dev_oe;
	ohb_byte_t host_data_bus;

	// undriven lines sit at ground
	assign host_data_bus = dev_oe ? dev_do : (host_oe ? host_do : BYTE_ZERO);

	modport host
	(
		output cs_n, dc, en_rd, rw_wr, reset_n, bus_select_bit0, bus_select_bit1,
		output host_do, host_oe,
		input  host_data_bus
	);
	modport device
	(
		input  cs_n, dc, en_rd, rw_wr, reset_n, bus_select_bit0, bus_select_bit1,
		output dev_do, dev_oe,
		input  host_data_bus
	);
endinterface

/* ohb_fifo.sv */
// small valid/ready buffer for received words
`timescale 1ns/1ps
module ohb_fifo
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
)
(
	input  wire logic             clk,       // system clock
	input  wire logic             sys_rst,   // async reset
	input  wire logic             flush,     // drop contents
	input  wire logic             in_valid,  // word offered
	output logic                  in_ready,  // space left
	input  wire logic [WIDTH-1:0] in_data,   // word in
	output logic                  out_valid, // word held
	input  wire logic             out_ready, // word taken
	output logic [WIDTH-1:0]      out_data   // oldest word
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = AW + 1;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("fifo depth must be a power of two, at least two");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0]    cnt_q, cnt_d, left;
	logic             full_q, full_d, empty_q, empty_d;
	logic             valid_q;
	logic [WIDTH-1:0] head_q, head_d;
	logic             push, pop;

	assign push      = in_valid && !full_q;
	assign pop       = out_ready && !empty_q;
	assign in_ready  = !full_q;
	assign out_valid = valid_q;
	assign out_data  = head_q;

	// registered head: incoming word when nothing else remains
	always_comb
	begin
		wp_d    = push ? wp_q + AW'(1) : wp_q;
		rp_d    = pop ? rp_q + AW'(1) : rp_q;
		cnt_d   = cnt_q + CW'(push) - CW'(pop);
		left    = cnt_q - CW'(pop);
		head_d  = (left == '0) ? in_data : mem[rp_d];
		if (flush)
		begin
			wp_d  = '0;
			rp_d  = '0;
			cnt_d = '0;
		end
		full_d  = (cnt_d == CW'(DEPTH));
		empty_d = (cnt_d == '0);
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wp_q    <= '0;
			rp_q    <= '0;
			cnt_q   <= '0;
			full_q  <= 1'b0;
			empty_q <= 1'b1;
			valid_q <= 1'b0;
			head_q  <= '0;
		end
		else
		begin
			wp_q    <= wp_d;
			rp_q    <= rp_d;
			cnt_q   <= cnt_d;
			full_q  <= full_d;
			empty_q <= empty_d;
			valid_q <= !empty_d;
			head_q  <= head_d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push && !flush)
			mem[wp_q] <= in_data;
	end
endmodule

/* ohb_host_end.sv */
// microcontroller side of the host bus port: cycle generator
`timescale 1ns/1ps
module ohb_host_end
(
	input  wire logic               clk,       // system clock
	input  wire logic               sys_rst,   // async reset
	ohb_link_if.host                lk,        // pins toward display
	input  wire ohb_pkg::ohb_mode_t mode,      // bus scheme strap
	input  wire logic               rst_req,   // hold display in reset
	input  wire logic               cmd_valid, // transfer requested
	output logic                    cmd_ready, // idle, takes request
	input  wire logic               cmd_read,  // 1 read (parallel modes only), 0 write
	input  wire logic               cmd_dc,    // 1 data, 0 command
	input  wire ohb_pkg::ohb_byte_t cmd_byte,  // write byte
	output logic                    rsp_valid, // read byte ready
	output ohb_pkg::ohb_byte_t      rsp_byte   // read byte
);
	import ohb_pkg::*;

	generate
		if (PAR_PHASE_CYC >= (1 << TMR_W) || SER_HALF_CYC >= (1 << TMR_W))
		begin : g_bad_timer
			$error("phase counts exceed the timer width");
		end
	endgenerate

	typedef enum logic [2:0]
	{
		H_IDLE   = 3'h0,
		H_SETUP  = 3'h1,
		H_STROBE = 3'h2,
		H_HOLD   = 3'h3,
		H_SLO    = 3'h4,
		H_SHI    = 3'h5
	} ohb_hstate_t;

	ohb_hstate_t          st_q, st_d;
	logic [TMR_W-1:0]     tmr_q, tmr_d;
	logic [SER_CNT_W-1:0] bit_q, bit_d;
	logic [WORD_W-1:0]    sh_q, sh_d;
	ohb_mode_t            md_q, md_d;
	logic                 rd_q, rd_d;
	logic                 cs_n_q, cs_n_d, dc_q, dc_d, en_q, en_d, rw_q, rw_d;
	logic                 oe_q, oe_d, rdy_q, rdy_d, rv_q, rv_d, rstn_q, rstn_d;
	ohb_byte_t            do_q, do_d, rb_q, rb_d;
	logic                 tdone;

	assign tdone = (tmr_q == '0);

	always_comb
	begin
		st_d   = st_q;
		tmr_d  = tdone ? tmr_q : tmr_q - TMR_W'(1);
		bit_d  = bit_q;
		sh_d   = sh_q;
		rd_d   = rd_q;
		cs_n_d = cs_n_q;
		dc_d   = dc_q;
		en_d   = en_q;
		rw_d   = rw_q;
		oe_d   = oe_q;
		do_d   = do_q;
		rb_d   = rb_q;
		rv_d   = 1'b0;
		rstn_d = !rst_req;
		case (st_q)
			H_IDLE:
			begin
				en_d = (md_q == OHB_PAR80);
				rw_d = (md_q == OHB_PAR80);
				if (cmd_valid && rdy_q && !rst_req)
				begin
					cs_n_d = 1'b0;
					rd_d   = cmd_read;
					if (ohb_is_serial(md_q))
					begin
						en_d  = 1'b0;                                  // [RULE5]
						rw_d  = 1'b0;                                  // [RULE5]
						dc_d  = (md_q == OHB_SER3) ? 1'b0 : cmd_dc;    // [RULE12]
						sh_d  = (md_q == OHB_SER3) ? {cmd_dc, cmd_byte} : {cmd_byte, 1'b0};
						bit_d = '0;
						oe_d  = 1'b1;
						do_d  = {BYTE_ZERO[BYTE_W-1:2], sh_d[WORD_W-1], 1'b0}; // [RULE8]
						tmr_d = TMR_W'(SER_HALF_CYC - 1);
						st_d  = H_SLO;
					end
					else
					begin
						dc_d  = cmd_dc;
						rw_d  = (md_q == OHB_PAR68) ? cmd_read : 1'b1; // [RULE3]
						oe_d  = !cmd_read;
						do_d  = cmd_read ? BYTE_ZERO : cmd_byte;
						tmr_d = TMR_W'(PAR_PHASE_CYC - 1);
						st_d  = H_SETUP;
					end
				end
			end
			H_SETUP:
				if (tdone)
				begin
					if (md_q == OHB_PAR68)
						en_d = 1'b1;
					else if (rd_q)
						en_d = 1'b0;
					else
						rw_d = 1'b0;
					tmr_d = TMR_W'(PAR_PHASE_CYC - 1);
					st_d  = H_STROBE;
				end
			H_STROBE:
				if (tdone)
				begin
					if (rd_q)
					begin
						rb_d = lk.host_data_bus;
						rv_d = 1'b1;
					end
					en_d  = (md_q == OHB_PAR80);
					rw_d  = (md_q == OHB_PAR80) ? 1'b1 : rw_q;
					tmr_d = TMR_W'(PAR_PHASE_CYC - 1);
					st_d  = H_HOLD;
				end
			H_SLO:
				if (tdone)
				begin
					do_d[SCLK_BIT] = 1'b1;
					tmr_d = TMR_W'(SER_HALF_CYC - 1);
					st_d  = H_SHI;
				end
			H_SHI:
				if (tdone)
				begin
					sh_d  = {sh_q[WORD_W-2:0], 1'b0};
					bit_d = bit_q + SER_CNT_W'(1);
					do_d  = {BYTE_ZERO[BYTE_W-1:2], sh_d[WORD_W-1], 1'b0};
					tmr_d = TMR_W'(SER_HALF_CYC - 1);
					st_d  = H_SLO;
					if (bit_d == ohb_ser_bits(md_q))
						st_d = H_HOLD;
				end
			default:
				if (tdone)
				begin
					cs_n_d = 1'b1;
					oe_d   = 1'b0;
					do_d   = BYTE_ZERO;
					st_d   = H_IDLE;
				end
		endcase
		// strap follows the pin only while idle, never on the take edge
		md_d  = (st_d == H_IDLE) ? mode : md_q;
		rdy_d = (st_d == H_IDLE) && !rst_req;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q   <= H_IDLE;
			tmr_q  <= '0;
			bit_q  <= '0;
			sh_q   <= '0;
			md_q   <= OHB_SER4;
			rd_q   <= 1'b0;
			cs_n_q <= 1'b1;
			dc_q   <= 1'b0;
			en_q   <= 1'b0;
			rw_q   <= 1'b0;
			oe_q   <= 1'b0;
			do_q   <= BYTE_ZERO;
			rb_q   <= BYTE_ZERO;
			rv_q   <= 1'b0;
			rdy_q  <= 1'b0;
			rstn_q <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			tmr_q  <= tmr_d;
			bit_q  <= bit_d;
			sh_q   <= sh_d;
			md_q   <= md_d;
			rd_q   <= rd_d;
			cs_n_q <= cs_n_d;
			dc_q   <= dc_d;
			en_q   <= en_d;
			rw_q   <= rw_d;
			oe_q   <= oe_d;
			do_q   <= do_d;
			rb_q   <= rb_d;
			rv_q   <= rv_d;
			rdy_q  <= rdy_d;
			rstn_q <= rstn_d;
		end
	end

	assign lk.cs_n            = cs_n_q;
	assign lk.dc              = dc_q;
	assign lk.en_rd           = en_q;
	assign lk.rw_wr           = rw_q;
	assign lk.reset_n         = rstn_q;
	assign lk.bus_select_bit0 = md_q[0];
	assign lk.bus_select_bit1 = md_q[1];
	assign lk.host_do         = do_q;
	assign lk.host_oe         = oe_q;
	assign cmd_ready          = rdy_q;
	assign rsp_valid          = rv_q;
	assign rsp_byte           = rb_q;
endmodule

/* ohb_link_checker.sv */
// protocol assertions on the link between host end and device end
`timescale 1ns/1ps
module ohb_link_checker
(
	input wire logic               clk,             // system clock
	input wire logic               sys_rst,         // async reset
	input wire logic               cs_n,            // chip select
	input wire logic               dc,              // data or command
	input wire logic               en_rd,           // enable or read strobe
	input wire logic               rw_wr,           // direction or write strobe
	input wire logic               bus_select_bit0, // mode strap low
	input wire logic               bus_select_bit1, // mode strap high
	input wire logic               host_oe,         // host drives bus
	input wire logic               dev_oe,          // device drives bus
	input wire ohb_pkg::ohb_byte_t host_data_bus    // resolved bus
);
	import ohb_pkg::*;
	logic [1:0] mode_sel;
	logic       ser;
	assign mode_sel = {bus_select_bit1, bus_select_bit0};
	assign ser = !bus_select_bit1;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// enable-style write: rise of enable with write selected
	sequence s_wr68_rise;
		mode_sel == OHB_PAR68 && !cs_n && !rw_wr && $rose(en_rd);
	endsequence
	// enable high six cycles, then low
	sequence s_en_pulse;
		en_rd [*6] ##1 !en_rd;
	endsequence

	serial_strobes_low_a: assert property (ser && !cs_n |-> !en_rd && !rw_wr)
		else $error("strobe pin not grounded in serial mode");
	three_wire_dc_a: assert property (mode_sel == OHB_SER3 && !cs_n |-> !dc)
		else $error("data/command pin high in three-wire mode");
	ser_unused_low_a: assert property (ser && !cs_n |-> host_data_bus[7:3] == 5'h00)
		else $error("unused data line driven in serial mode");
	sclk_high_two_a: assert property (ser && !cs_n && $rose(host_data_bus[0])
		|=> host_data_bus[0])
		else $error("serial clock high phase too short");
	read68_start_a: assert property ($rose(dev_oe) && mode_sel == OHB_PAR68
		|-> !$past(cs_n) && $past(en_rd) && $past(rw_wr))
		else $error("enable-style read drive without enable and read select");
	read80_start_a: assert property ($rose(dev_oe) && mode_sel == OHB_PAR80
		|-> !$past(cs_n) && !$past(en_rd))
		else $error("strobe-style read drive without low read strobe");
	bus_release_a: assert property (cs_n ##1 cs_n |-> !dev_oe)
		else $error("device drives bus while deselected");
	read_idle_a: assert property ((!ser && (bus_select_bit0 ? !en_rd : en_rd)) [*2]
		|-> !dev_oe)
		else $error("device drives bus outside a read cycle");
	no_contention_a: assert property (!(host_oe && dev_oe))
		else $error("host and device drive the bus together");
	write68_hold_a: assert property (s_wr68_rise
		|-> (host_oe && !cs_n && $stable(host_data_bus)) throughout s_en_pulse)
		else $error("write data not held over enable pulse");
	write80_strobe_a: assert property (mode_sel == OHB_PAR80 && !cs_n && $fell(rw_wr)
		|-> host_oe && en_rd)
		else $error("strobe-style write without host drive");
endmodule

/* tb_top.sv */
// self-checking bench: host end and device end joined by the link
`timescale 1ns/1ps
module tb_top;
	import ohb_pkg::*;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	ohb_mode_t  mode = OHB_PAR68;
	logic       rst_req = 1'b0;
	logic       cmd_valid = 1'b0;
	logic       cmd_ready;
	logic       cmd_read = 1'b0;
	logic       cmd_dc = 1'b0;
	ohb_byte_t  cmd_byte = 8'h00;
	logic       rsp_valid;
	ohb_byte_t  rsp_byte;
	ohb_byte_t  read_byte = 8'h00;
	logic       read_strobe;
	logic       out_valid;
	logic       out_ready = 1'b1;
	ohb_byte_t  out_byte;
	logic       out_is_data;
	logic       init_active;
	logic       lost_word;
	logic       sclk_q = 1'b0;
	logic [8:0] ser_sh = 9'h000;
	int         rd_cnt = 0;
	int         error_cnt = 0;
	int         check_count = 0;

	ohb_link_if lk ();
	ohb_host_end i_ohb_host_end (.clk(clk), .sys_rst(sys_rst), .lk(lk.host), .mode(mode),
		.rst_req(rst_req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
		.cmd_dc(cmd_dc), .cmd_byte(cmd_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
	ohb_device_end #(.DEPTH(2)) i_ohb_device_end (.clk(clk), .sys_rst(sys_rst), .lk(lk.device),
		.read_byte(read_byte), .read_strobe(read_strobe), .out_valid(out_valid),
		.out_ready(out_ready), .out_byte(out_byte), .out_is_data(out_is_data),
		.init_active(init_active), .lost_word(lost_word));
	ohb_link_checker i_ohb_link_checker (.clk(clk), .sys_rst(sys_rst), .cs_n(lk.cs_n),
		.dc(lk.dc), .en_rd(lk.en_rd), .rw_wr(lk.rw_wr), .bus_select_bit0(lk.bus_select_bit0),
		.bus_select_bit1(lk.bus_select_bit1), .host_oe(lk.host_oe), .dev_oe(lk.dev_oe),
		.host_data_bus(lk.host_data_bus));

	always #12.5 clk = ~clk;

	// serial bits as seen on the wire, read starts counted
	always @(posedge clk)
	begin
		sclk_q <= lk.host_data_bus[0];
		if (!sclk_q && lk.host_data_bus[0] && !lk.cs_n)
			ser_sh <= {ser_sh[7:0], lk.host_data_bus[1]};
		if (read_strobe)
			rd_cnt <= rd_cnt + 1;
	end

	task automatic tick();
		@(posedge clk);
		#2;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk8(input ohb_byte_t got, input ohb_byte_t exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask

	function automatic logic sig(input int k);
		case (k)
			0: sig = cmd_ready;
			1: sig = rsp_valid;
			default: sig = out_valid;
		endcase
	endfunction

	task automatic wait_sig(input int k);
		int n;
		n = 0;
		while (sig(k) !== 1'b1)
		begin
			tick();
			n++;
			if (n > 400)
			begin
				error_cnt++;
				$display("BAD %0t wait %0d timed out", $time, k);
				close_out();
			end
		end
	endtask

	// one request, then a spare cycle so it is not taken twice
	task automatic send(input logic rd, input logic d, input ohb_byte_t b);
		wait_sig(0);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_dc = d;
		cmd_byte = b;
		tick();
		cmd_valid = 1'b0;
		tick();
	endtask

	task automatic t_write();
		ohb_mode_t ms[4] = '{OHB_PAR68, OHB_PAR80, OHB_SER4, OHB_SER3};
		ohb_byte_t bs[8] = '{8'hA5, 8'h00, 8'h80, 8'hFF, 8'h01, 8'hC3, 8'h7E, 8'h5A};
		for (int i = 0; i < 8; i++)
		begin
			wait_sig(0);
			mode = ms[i/2];
			repeat (3) tick();
			send(1'b0, i[0], bs[i]);
			wait_sig(2);
			chk8(out_byte, bs[i], "write byte");
			chk1(out_is_data, i[0], "write kind");
			if (i >= 4)
				chk8(ser_sh[7:0], bs[i], "serial wire bits");
			if (i >= 6)
				chk1(ser_sh[8], i[0], "serial kind bit");
			tick();
		end
		$display("t_write done");
	endtask

	task automatic t_read();
		ohb_byte_t rv[4] = '{8'h96, 8'h00, 8'hFF, 8'h69};
		int r0;
		for (int i = 0; i < 4; i++)
		begin
			wait_sig(0);
			mode = (i < 2) ? OHB_PAR68 : OHB_PAR80;
			read_byte = rv[i];
			r0 = rd_cnt;
			if (i % 2 == 0)
				repeat (3) tick();
			send(1'b1, 1'b1, 8'h00);
			wait_sig(1);
			chk8(rsp_byte, rv[i], "read byte");
			chk1(rd_cnt == r0 + 1, 1'b1, "one read start");
			repeat (2) tick();
			chk1(lk.dev_oe, 1'b0, "bus released");
		end
		$display("t_read done");
	endtask

	task automatic t_stall();
		ohb_byte_t bs[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
		ohb_byte_t ex[3] = '{8'h11, 8'h22, 8'h44};
		wait_sig(0);
		mode = OHB_PAR80;
		out_ready = 1'b0;
		repeat (3) tick();
		for (int i = 0; i < 4; i++)
			send(1'b0, 1'b1, bs[i]);
		wait_sig(0);
		repeat (4) tick();
		chk1(lost_word, 1'b1, "overflow flagged");
		out_ready = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			wait_sig(2);
			chk8(out_byte, ex[i], "drained byte");
			tick();
		end
		chk1(out_valid, 1'b0, "buffer empty");
		$display("t_stall done");
	endtask

	task automatic t_disp_reset();
		wait_sig(0);
		rst_req = 1'b1;
		repeat (3) tick();
		chk1(lk.reset_n, 1'b0, "reset pin low");
		chk1(init_active, 1'b1, "init during reset");
		chk1(lost_word, 1'b0, "loss flag cleared");
		rst_req = 1'b0;
		repeat (3) tick();
		chk1(init_active, 1'b0, "init over");
		$display("t_disp_reset done");
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		#2;
		sys_rst = 1'b0;
		t_write();
		t_read();
		t_stall();
		t_disp_reset();
		close_out();
	end
endmodule
